/* dcd_pkg.sv */
/*
  Shared constants, encodings and the recovery sequence table of the
  command decoder pair. Assumes a single 200 MHz clock on both ends.
*/
package dcd_pkg;

  // ---------------------------------------------------------------
  // Widths and timing
  // ---------------------------------------------------------------
  localparam int BA_W          = 3;
  localparam int ADDR_W        = 14;
  localparam int NUM_BANKS     = 8;
  localparam int CLK_PS        = 5000;
  localparam int TDELAY_NS     = 20;
  localparam int TDELAY_CYC    = (TDELAY_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CLK_STABLE_NS = 200;
  localparam int CLK_STABLE_CYC =
    (CLK_STABLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int INIT_GAP_CYC  = 4;
  localparam int INIT_STEPS    = 10;

  // ---------------------------------------------------------------
  // Address field positions and mode values
  // ---------------------------------------------------------------
  localparam int A10_POS      = 10;
  localparam int DLL_RST_POS  = 8;
  localparam logic [2:0] BL4_CODE = 3'h2;
  localparam logic [2:0] BL8_CODE = 3'h3;
  localparam logic [2:0] BL4_HALF = 3'h2;
  localparam logic [2:0] BL8_HALF = 3'h4;

  // ---------------------------------------------------------------
  // Decoded commands
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    C_NOP  = 4'h0, C_MRS  = 4'h1, C_REF  = 4'h2, C_SRE  = 4'h3,
    C_PRE  = 4'h4, C_PREA = 4'h5, C_ACT  = 4'h6, C_WR   = 4'h7,
    C_WRA  = 4'h8, C_RD   = 4'h9, C_RDA  = 4'ha, C_PDE  = 4'hb,
    C_EXIT = 4'hc, C_ILL  = 4'hd, C_HOLD = 4'he
  } dcd_cmd_t;

  // Device power and recovery state, Gray along the usual path
  typedef enum logic [1:0] {
    S_ACTIVE = 2'h0, S_PDOWN = 2'h1, S_SREF = 2'h3, S_REINIT = 2'h2
  } dcd_dev_st_t;

  // Recovery sequence: command and bank for each step
  function automatic logic [6:0] init_step(input logic [3:0] idx);
    case (idx)
      4'h0:    init_step = {C_PREA, 3'h0};
      4'h1:    init_step = {C_MRS,  3'h2};
      4'h2:    init_step = {C_MRS,  3'h3};
      4'h3:    init_step = {C_MRS,  3'h1};
      4'h4:    init_step = {C_MRS,  3'h0};
      4'h5:    init_step = {C_PREA, 3'h0};
      4'h6:    init_step = {C_REF,  3'h0};
      4'h7:    init_step = {C_REF,  3'h0};
      4'h8:    init_step = {C_MRS,  3'h0};
      4'h9:    init_step = {C_MRS,  3'h1};
      default: init_step = {C_NOP,  3'h0};
    endcase
  endfunction

endpackage

/* dcd_if.sv */
/*
  Command and address pins between controller and memory device.
  Assumes both ends share one clock; clk_run shows the clock toggling.
*/
`timescale 1ns/1ps
interface dcd_if;

  // ---------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------
  logic                      cke;
  logic                      cs_n;
  logic                      ras_n;
  logic                      cas_n;
  logic                      we_n;
  logic [dcd_pkg::BA_W-1:0]  ba;
  logic [dcd_pkg::ADDR_W-1:0] a;
  logic                      odt;
  logic                      clk_run;

  modport dev (
    input cke, cs_n, ras_n, cas_n, we_n, ba, a, odt, clk_run
  );
  modport ctl (
    output cke, cs_n, ras_n, cas_n, we_n, ba, a, odt, clk_run
  );

endinterface

/* dcd_device.sv */
/*
  Device end: decodes sampled CKE history and command pins into
  commands, tracks power state, bursts, open banks and recovery.
  Assumes pins are synchronous to clk_i and driven by the controller.
*/
`timescale 1ns/1ps

module dcd_device (
  input  wire logic                        clk_i,
  input  wire logic                        nrst_i,
  dcd_if.dev                               pins,
  output logic                             cmd_valid_o,
  output logic [3:0]                       cmd_o,
  output logic [dcd_pkg::BA_W-1:0]         bank_o,
  output logic [dcd_pkg::ADDR_W-1:0]       addr_o,
  output logic                             mr_we_o,
  output logic [1:0]                       state_o,
  output logic                             burst_o,
  output logic [dcd_pkg::NUM_BANKS-1:0]    bank_open_o,
  output logic                             init_done_o,
  output logic                             array_lost_o,
  output logic                             odt_en_o
);

  // -------------------------------------------------------------
  // Command decode
  // -------------------------------------------------------------
  function automatic logic [3:0] decode(input logic prev, input logic cur,
    input logic cs_n, input logic [2:0] rcw, input logic a10);
    logic nop_like;
    nop_like = cs_n || (rcw == 3'h7);
    if (!prev) begin
      // Only exit encodings count while CKE was low
      decode = (cur && nop_like) ? dcd_pkg::C_EXIT : dcd_pkg::C_HOLD;
    end else if (!cur) begin
      decode = nop_like ? dcd_pkg::C_PDE :
               ((rcw == 3'h1) ? dcd_pkg::C_SRE : dcd_pkg::C_ILL);
    end else if (cs_n) begin
      decode = dcd_pkg::C_NOP;
    end else begin
      case (rcw)
        3'h0:    decode = dcd_pkg::C_MRS;
        3'h1:    decode = dcd_pkg::C_REF;
        3'h2:    decode = a10 ? dcd_pkg::C_PREA : dcd_pkg::C_PRE;
        3'h3:    decode = dcd_pkg::C_ACT;
        3'h4:    decode = a10 ? dcd_pkg::C_WRA : dcd_pkg::C_WR;
        3'h5:    decode = a10 ? dcd_pkg::C_RDA : dcd_pkg::C_RD;
        3'h7:    decode = dcd_pkg::C_NOP;
        default: decode = dcd_pkg::C_ILL;
      endcase
    end
  endfunction

  logic                        cke_q;
  logic [3:0]                  cmd;
  logic                        is_rw;
  logic                        is_ap;
  dcd_pkg::dcd_dev_st_t        st_q;
  dcd_pkg::dcd_dev_st_t        st_d;
  logic                        acc;
  logic                        lost;
  logic [3:0]                  step_q;
  logic [2:0]                  bcnt_q;
  logic                        bl4_q;
  logic [6:0]                  step_exp;

  // Previous-cycle CKE level
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cke_q <= 1'b0;
    end else begin
      cke_q <= pins.cke;
    end
  end

  // Decode of the sampled pins, ODT takes no part
  assign cmd = decode(cke_q, pins.cke, pins.cs_n,
                      {pins.ras_n, pins.cas_n, pins.we_n},
                      pins.a[dcd_pkg::A10_POS]);
  assign is_rw = (cmd == dcd_pkg::C_RD) || (cmd == dcd_pkg::C_RDA) ||
                 (cmd == dcd_pkg::C_WR) || (cmd == dcd_pkg::C_WRA);
  assign is_ap = (cmd == dcd_pkg::C_RDA) || (cmd == dcd_pkg::C_WRA);
  assign burst_o = (bcnt_q != 3'h0);
  assign step_exp = dcd_pkg::init_step(step_q);

  // -------------------------------------------------------------
  // Power and recovery state machine
  // -------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    acc  = 1'b0;
    lost = 1'b0;
    case (st_q)
      dcd_pkg::S_ACTIVE: begin
        case (cmd)
          dcd_pkg::C_SRE, dcd_pkg::C_PDE: begin
            lost = burst_o;
            acc  = !burst_o;
            st_d = (cmd == dcd_pkg::C_SRE) ? dcd_pkg::S_SREF :
                   dcd_pkg::S_PDOWN;
          end
          dcd_pkg::C_ILL: begin
            lost = !pins.cke;
          end
          dcd_pkg::C_MRS, dcd_pkg::C_REF, dcd_pkg::C_PRE,
          dcd_pkg::C_PREA, dcd_pkg::C_ACT: begin
            acc = 1'b1;
          end
          dcd_pkg::C_RD, dcd_pkg::C_RDA, dcd_pkg::C_WR,
          dcd_pkg::C_WRA: begin
            acc = !(bl4_q && burst_o);
          end
          default: begin
            acc = 1'b0;
          end
        endcase
        st_d = lost ? dcd_pkg::S_REINIT : st_d;
      end
      dcd_pkg::S_PDOWN, dcd_pkg::S_SREF: begin
        acc = (st_q == dcd_pkg::S_SREF) ? pins.cke :
              (cmd == dcd_pkg::C_EXIT);
        if (acc) begin
          st_d = dcd_pkg::S_ACTIVE;
        end
      end
      dcd_pkg::S_REINIT: begin
        if (cke_q && !pins.cke) begin
          lost = 1'b1;
        end else if (cmd == step_exp[6:3] &&
                     (cmd != dcd_pkg::C_MRS ||
                      pins.ba == step_exp[2:0])) begin
          acc = 1'b1;
          if (step_q == 4'(dcd_pkg::INIT_STEPS - 1)) begin
            st_d = dcd_pkg::S_ACTIVE;
          end
        end
      end
      default: begin
        st_d = dcd_pkg::S_REINIT;
      end
    endcase
  end

  // State register; reset leaves the device awaiting initialization
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= dcd_pkg::S_REINIT;
    end else begin
      st_q <= st_d;
    end
  end

  // Recovery step counter
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      step_q <= 4'h0;
    end else if (lost) begin
      step_q <= 4'h0;
    end else if (acc && st_q == dcd_pkg::S_REINIT) begin
      step_q <= (st_d == dcd_pkg::S_ACTIVE) ? 4'h0 : step_q + 4'h1;
    end
  end

  // Array loss flag, held until recovery completes
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      array_lost_o <= 1'b0;
    end else if (lost) begin
      array_lost_o <= 1'b1;
    end else if (st_q == dcd_pkg::S_REINIT &&
                 st_d == dcd_pkg::S_ACTIVE) begin
      array_lost_o <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // Bursts and mode
  // -------------------------------------------------------------
  // Burst length from mode register zero
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bl4_q <= 1'b1;
    end else if (acc && cmd == dcd_pkg::C_MRS && pins.ba == 3'h0) begin
      bl4_q <= (pins.a[2:0] == dcd_pkg::BL4_CODE);
    end
  end

  // Burst cycle counter; NOP and deselect let it run out
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bcnt_q <= 3'h0;
    end else if (lost) begin
      bcnt_q <= 3'h0;
    end else if (acc && is_rw) begin
      bcnt_q <= bl4_q ? dcd_pkg::BL4_HALF : dcd_pkg::BL8_HALF;
    end else if (burst_o) begin
      bcnt_q <= bcnt_q - 3'h1;
    end
  end

  // Open row per bank
  genvar b;
  generate
    for (b = 0; b < dcd_pkg::NUM_BANKS; b++) begin : g_bank
      logic hit;
      assign hit = (pins.ba == 3'(b));
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          bank_open_o[b] <= 1'b0;
        end else if (lost || (acc && cmd == dcd_pkg::C_PREA)) begin
          bank_open_o[b] <= 1'b0;
        end else if (acc && hit) begin
          if (cmd == dcd_pkg::C_ACT) begin
            bank_open_o[b] <= 1'b1;
          end else if (cmd == dcd_pkg::C_PRE || is_ap) begin
            bank_open_o[b] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // -------------------------------------------------------------
  // Command outputs
  // -------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmd_valid_o <= 1'b0;
      cmd_o       <= dcd_pkg::C_NOP;
      bank_o      <= '0;
      addr_o      <= '0;
      mr_we_o     <= 1'b0;
    end else begin
      cmd_valid_o <= acc;
      mr_we_o     <= acc && (cmd == dcd_pkg::C_MRS);
      if (acc) begin
        cmd_o  <= (st_q == dcd_pkg::S_SREF) ? dcd_pkg::C_EXIT : cmd;
        bank_o <= pins.ba;
        addr_o <= pins.a;
      end
    end
  end

  // Status outputs
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_o     <= dcd_pkg::S_REINIT;
      init_done_o <= 1'b0;
      odt_en_o    <= 1'b0;
    end else begin
      state_o     <= st_d;
      init_done_o <= (st_d != dcd_pkg::S_REINIT);
      odt_en_o    <= pins.odt && (st_d != dcd_pkg::S_SREF);
    end
  end

endmodule

/* dcd_ctrl.sv */
/*
  Controller end: drives command pins from a user request port,
  limits power-down time and recovers from a forced CKE drop.
  Assumes the device end samples the pins on the same clk_i.
*/
`timescale 1ns/1ps
module dcd_ctrl #(
  parameter int                     PD_MAX_CYC = 14040,
  parameter logic [13:0]            MR0_VAL    = 14'h0002
) (
  input  wire logic                        clk_i,
  input  wire logic                        nrst_i,
  dcd_if.ctl                               pins,
  input  wire logic                        req_valid_i,
  input  wire logic [3:0]                  req_cmd_i,
  input  wire logic [dcd_pkg::BA_W-1:0]    req_bank_i,
  input  wire logic [dcd_pkg::ADDR_W-1:0]  req_addr_i,
  input  wire logic                        odt_i,
  input  wire logic                        cke_drop_i,
  input  wire logic                        wake_i,
  output logic                             req_ready_o,
  output logic                             recovering_o
);

  // -------------------------------------------------------------
  // State and counters
  // -------------------------------------------------------------
  typedef enum logic [2:0] {
    K_RUN = 3'h0, K_DROP = 3'h1, K_STOP = 3'h3,
    K_RESTORE = 3'h2, K_REINIT = 3'h6
  } dcd_ctl_st_t;

  dcd_ctl_st_t  st_q;
  logic [15:0]  cnt_q;
  logic [3:0]   step_q;
  logic [15:0]  pd_q;
  logic         pd_force;
  logic [6:0]   step;

  // Pin level encoding {cs_n, ras_n, cas_n, we_n}
  function automatic logic [3:0] encode(input logic [3:0] c);
    case (c)
      dcd_pkg::C_MRS:                  encode = 4'h0;
      dcd_pkg::C_REF, dcd_pkg::C_SRE:  encode = 4'h1;
      dcd_pkg::C_PRE, dcd_pkg::C_PREA: encode = 4'h2;
      dcd_pkg::C_ACT:                  encode = 4'h3;
      dcd_pkg::C_WR, dcd_pkg::C_WRA:   encode = 4'h4;
      dcd_pkg::C_RD, dcd_pkg::C_RDA:   encode = 4'h5;
      dcd_pkg::C_EXIT:                 encode = 4'hf;
      default:                         encode = 4'h7;
    endcase
  endfunction

  assign step     = dcd_pkg::init_step(step_q);
  assign pd_force = !pins.cke && (pd_q >= 16'(PD_MAX_CYC));
  assign req_ready_o  = (st_q == K_RUN) && !pd_force;
  assign recovering_o = (st_q != K_RUN);

  // Sequencing of drop, clock stop, restore and re-initialization
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q   <= K_REINIT;
      cnt_q  <= 16'(dcd_pkg::INIT_GAP_CYC);
      step_q <= 4'h0;
    end else begin
      case (st_q)
        K_RUN: begin
          if (cke_drop_i) begin
            st_q  <= K_DROP;
            cnt_q <= 16'(dcd_pkg::TDELAY_CYC);
          end
        end
        K_DROP: begin
          if (cnt_q <= 16'h1) begin
            st_q <= K_STOP;
          end else begin
            cnt_q <= cnt_q - 16'h1;
          end
        end
        K_STOP: begin
          if (wake_i) begin
            st_q  <= K_RESTORE;
            cnt_q <= 16'(dcd_pkg::CLK_STABLE_CYC);
          end
        end
        K_RESTORE: begin
          if (cnt_q <= 16'h1) begin
            st_q   <= K_REINIT;
            cnt_q  <= 16'(dcd_pkg::INIT_GAP_CYC);
            step_q <= 4'h0;
          end else begin
            cnt_q <= cnt_q - 16'h1;
          end
        end
        K_REINIT: begin
          if (cnt_q != 16'h0) begin
            cnt_q <= cnt_q - 16'h1;
          end else if (step_q == 4'(dcd_pkg::INIT_STEPS - 1)) begin
            st_q   <= K_RUN;
            step_q <= 4'h0;
          end else begin
            step_q <= step_q + 4'h1;
            cnt_q  <= 16'(dcd_pkg::INIT_GAP_CYC);
          end
        end
        default: begin
          st_q <= K_REINIT;
        end
      endcase
    end
  end

  // Power-down duration counter
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pd_q <= '0;
    end else if (pins.cke || st_q != K_RUN) begin
      pd_q <= '0;
    end else if (!pd_force) begin
      pd_q <= pd_q + 16'h1;
    end
  end

  // -------------------------------------------------------------
  // Pin drive; unused inputs always at defined levels
  // -------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pins.cke     <= 1'b0;
      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'hf;
      pins.ba      <= '0;
      pins.a       <= '0;
      pins.odt     <= 1'b0;
      pins.clk_run <= 1'b1;
    end else begin
      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h7;
      pins.ba  <= '0;
      pins.a   <= '0;
      pins.odt <= odt_i && pins.cke && st_q == K_RUN;
      case (st_q)
        K_RUN: begin
          if (cke_drop_i) begin
            pins.cke <= 1'b0;
          end else if (pd_force) begin
            pins.cke <= 1'b1;
          end else if (req_valid_i) begin
            {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <=
              encode(req_cmd_i);
            pins.ba <= req_bank_i;
            pins.a  <= req_addr_i;
            if (req_cmd_i == dcd_pkg::C_PREA) begin
              pins.a[dcd_pkg::A10_POS] <= 1'b1;
            end
            if (req_cmd_i == dcd_pkg::C_SRE ||
                req_cmd_i == dcd_pkg::C_PDE) begin
              pins.cke <= 1'b0;
            end else if (req_cmd_i == dcd_pkg::C_EXIT) begin
              pins.cke <= 1'b1;
            end
          end
        end
        K_STOP: begin
          pins.clk_run <= wake_i;
        end
        K_RESTORE: begin
          pins.clk_run <= 1'b1;
          pins.cke     <= (cnt_q <= 16'h1);
        end
        K_REINIT: begin
          pins.cke <= 1'b1;
          if (cnt_q == 16'h0) begin
            {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <=
              encode(step[6:3]);
            pins.ba <= step[2:0];
            if (step[6:3] == dcd_pkg::C_PREA) begin
              pins.a[dcd_pkg::A10_POS] <= 1'b1;
            end else if (step_q == 4'h4) begin
              pins.a <= MR0_VAL;
              pins.a[dcd_pkg::DLL_RST_POS] <= 1'b1;
            end else if (step_q == 4'h8) begin
              pins.a <= MR0_VAL;
            end
          end
        end
        default: begin
          pins.cke <= 1'b0;
        end
      endcase
    end
  end

endmodule

/* dcd_assertions.sv */
/*
  Pin checks on the link between controller and device ends.
  Assumes it is instantiated beside the shared dcd_if instance.
*/
`timescale 1ns/1ps
module dcd_assertions #(
  parameter int PD_MAX_CYC = 14040
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        cke,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [2:0]  ba,
  input  wire logic [13:0] a,
  input  wire logic        clk_run
);
  // ---------------------------------------------------------------
  // Clock-running and power-down length counters
  // ---------------------------------------------------------------
  logic        sr_q;
  logic [15:0] pd_cnt_q;
  logic [3:0]  run_cnt_q;

  // Clock-running cycles, saturating; the clock runs through reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i)
      run_cnt_q <= 4'h8;
    else if (!clk_run)
      run_cnt_q <= 4'h0;
    else if (run_cnt_q != 4'h8)
      run_cnt_q <= run_cnt_q + 4'h1;
  end

  // Remember whether the last clock-enable fall was a self-refresh
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i)
      sr_q <= 1'b0;
    else if ($fell(cke))
      sr_q <= !cs_n && !ras_n;
  end

  // Count low clock-enable cycles of a power-down
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i)
      pd_cnt_q <= 16'h0;
    else if (cke || !clk_run || sr_q)
      pd_cnt_q <= 16'h0;
    else
      pd_cnt_q <= pd_cnt_q + 16'h1;
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  property p_clk_hold; $fell(cke) |=> clk_run [*3]; endproperty
  a_clk_hold: assert property (p_clk_hold)
    else $error("clock stopped too soon after enable fell");
  property p_clk_stop; $fell(clk_run) |-> !cke && !$past(cke, 3); endproperty
  a_clk_stop: assert property (p_clk_stop)
    else $error("clock stopped without delay");
  property p_cke_clk; !clk_run |-> !cke; endproperty
  a_cke_clk: assert property (p_cke_clk)
    else $error("enable high with clock stopped");
  property p_cke_stable; $rose(cke) |-> run_cnt_q == 4'h8; endproperty
  a_cke_stable: assert property (p_cke_stable)
    else $error("enable raised before clock stable");
  property p_exit_nop; $rose(cke) |-> cs_n || (ras_n && cas_n && we_n);
  endproperty
  a_exit_nop: assert property (p_exit_nop)
    else $error("enable raised without idle command");
  property p_reinit;
    $rose(clk_run) |-> ##[1:100] (cke && !cs_n && !ras_n && cas_n && !we_n
                                  && a[10]);
  endproperty
  a_reinit: assert property (p_reinit)
    else $error("no precharge-all after clock restart");
  property p_mr_bank; cke && !cs_n && !ras_n && !cas_n && !we_n |-> !ba[2];
  endproperty
  a_mr_bank: assert property (p_mr_bank)
    else $error("mode write to unknown register");
  property p_pd_limit; pd_cnt_q <= PD_MAX_CYC + 2; endproperty
  a_pd_limit: assert property (p_pd_limit)
    else $error("power-down too long");
endmodule

/* tb_top.sv */
/*
  Self-checking bench joining controller and device through dcd_if.
  Assumes dcd_pkg, dcd_if and both design ends are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  localparam int PD_MAX = 50;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        req_valid_i = 1'b0;
  logic [3:0]  req_cmd_i = 4'h0;
  logic [2:0]  req_bank_i = 3'h0;
  logic [13:0] req_addr_i = 14'h0;
  logic        odt_i = 1'b0;
  logic        cke_drop_i = 1'b0;
  logic        wake_i = 1'b0;
  logic        req_ready_o, recovering_o, cmd_valid_o, mr_we_o;
  logic        burst_o, init_done_o, array_lost_o, odt_en_o;
  logic [3:0]  cmd_o;
  logic [2:0]  bank_o;
  logic [13:0] addr_o;
  logic [1:0]  state_o;
  logic [7:0]  bank_open_o;
  int          fails = 0;
  int          total_checks = 0;

  // Clock and the two ends
  always #2.5 clk_i = ~clk_i;
  dcd_if i_dcd_if ();
  dcd_ctrl #(.PD_MAX_CYC(PD_MAX)) i_dcd_ctrl (.clk_i, .nrst_i,
    .pins(i_dcd_if), .req_valid_i, .req_cmd_i, .req_bank_i, .req_addr_i,
    .odt_i, .cke_drop_i, .wake_i, .req_ready_o, .recovering_o);
  dcd_device i_dcd_device (.clk_i, .nrst_i, .pins(i_dcd_if), .cmd_valid_o,
    .cmd_o, .bank_o, .addr_o, .mr_we_o, .state_o, .burst_o, .bank_open_o,
    .init_done_o, .array_lost_o, .odt_en_o);
  dcd_assertions #(.PD_MAX_CYC(PD_MAX)) i_dcd_assertions (.clk_i, .nrst_i,
    .cke(i_dcd_if.cke), .cs_n(i_dcd_if.cs_n), .ras_n(i_dcd_if.ras_n),
    .cas_n(i_dcd_if.cas_n), .we_n(i_dcd_if.we_n), .ba(i_dcd_if.ba),
    .a(i_dcd_if.a), .clk_run(i_dcd_if.clk_run));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [13:0] exp,
                     input logic [13:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bounded wait for the request port to open
  task automatic wait_ready;
    int n;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 3000) begin
      fails++;
      print_verdict();
    end
  endtask

  // One request, then check the decoded command a cycle later
  task automatic cmd(input logic [3:0] c, input logic [2:0] b,
                     input logic [13:0] ad);
    wait_ready();
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_cmd_i <= c;
    req_bank_i <= b;
    req_addr_i <= ad;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("cmd_valid", 14'h1, cmd_valid_o);
    chk("cmd", c, cmd_o);
    chk("bank", b, bank_o);
    chk("addr", ad, addr_o);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    wait_ready();
    @(posedge clk_i);
    odt_i <= 1'b1;
    #1;
    chk("init_done", 14'h1, init_done_o);
    $display("test reset done");
    cmd(dcd_pkg::C_MRS, 3'h1, 14'h0);
    chk("mr_we", 14'h1, mr_we_o);
    cmd(dcd_pkg::C_REF, 3'h0, 14'h0);
    cmd(dcd_pkg::C_ACT, 3'h2, 14'h0123);
    chk("open", 14'h4, bank_open_o);
    cmd(dcd_pkg::C_RD, 3'h2, 14'h0);
    chk("burst", 14'h1, burst_o);
    repeat (3) @(posedge clk_i);
    cmd(dcd_pkg::C_WR, 3'h2, 14'h0);
    cmd(dcd_pkg::C_PRE, 3'h2, 14'h0);
    chk("open", 14'h0, bank_open_o);
    cmd(dcd_pkg::C_ACT, 3'h5, 14'h0);
    cmd(dcd_pkg::C_RDA, 3'h5, 14'h0400);
    chk("open", 14'h0, bank_open_o);
    cmd(dcd_pkg::C_PREA, 3'h0, 14'h0400);
    $display("test decode done");
    cmd(dcd_pkg::C_PDE, 3'h0, 14'h0);
    chk("state", 14'h1, state_o);
    cmd(dcd_pkg::C_EXIT, 3'h0, 14'h0);
    chk("state", 14'h0, state_o);
    cmd(dcd_pkg::C_SRE, 3'h0, 14'h0);
    chk("state", 14'h3, state_o);
    chk("odt_en", 14'h0, odt_en_o);
    cmd(dcd_pkg::C_EXIT, 3'h0, 14'h0);
    @(posedge clk_i);
    #1;
    chk("odt_en", 14'h1, odt_en_o);
    cmd(dcd_pkg::C_PDE, 3'h0, 14'h0);
    repeat (PD_MAX + 10) @(posedge clk_i);
    #1;
    chk("state", 14'h0, state_o);
    $display("test power done");
    // Long burst, then a forced enable drop in the middle of it
    cmd(dcd_pkg::C_MRS, 3'h0, 14'h0003);
    cmd(dcd_pkg::C_ACT, 3'h1, 14'h0);
    cmd(dcd_pkg::C_RD, 3'h1, 14'h0);
    @(posedge clk_i);
    cke_drop_i <= 1'b1;
    @(posedge clk_i);
    cke_drop_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    chk("array_lost", 14'h1, array_lost_o);
    chk("init_done", 14'h0, init_done_o);
    chk("recovering", 14'h1, recovering_o);
    repeat (4) @(posedge clk_i);
    wake_i <= 1'b1;
    wait_ready();
    @(posedge clk_i);
    #1;
    chk("array_lost", 14'h0, array_lost_o);
    chk("init_done", 14'h1, init_done_o);
    cmd(dcd_pkg::C_ACT, 3'h3, 14'h0);
    $display("test drop done");
    print_verdict();
  end
endmodule
